// ===== design/acr_pkg.sv
// acr_pkg: shared constants of the converter command and register block.
// assumes both ends and the byte link run on one 250 MHz ref_clk.
package acr_pkg;
    // command byte patterns and don't-care masks
    localparam logic [7:0] CMD_RDATA_VAL = 8'h10;
    localparam logic [7:0] CMD_RDATA_MSK = 8'hF0;
    localparam logic [7:0] CMD_FETCH_VAL = 8'h20;
    localparam logic [7:0] CMD_FETCH_MSK = 8'hF8;
    localparam logic [7:0] CMD_STORE_VAL = 8'h40;
    localparam logic [7:0] CMD_STORE_MSK = 8'hFC;
    localparam int CMD_ADDR_BIT = 2;

    // register map
    localparam logic OFS_CONFIG = 1'h0;
    localparam logic OFS_STATUS = 1'h1;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int STAT_READY_BIT = 7;

    // configuration field positions
    localparam int CFG_INSEL_HI = 7;
    localparam int CFG_INSEL_LO = 5;
    localparam int CFG_GAIN_BIT = 4;
    localparam int CFG_RATE_HI = 3;
    localparam int CFG_RATE_LO = 2;
    localparam int CFG_MODE_BIT = 1;
    localparam int CFG_VREF_BIT = 0;

    // decoded values
    localparam logic [2:0] GAIN_LOW = 3'h1;
    localparam logic [2:0] GAIN_HIGH = 3'h4;
    localparam logic [9:0] RATE_SPS_0 = 10'h014;
    localparam logic [9:0] RATE_SPS_1 = 10'h05A;
    localparam logic [9:0] RATE_SPS_2 = 10'h14A;
    localparam logic [9:0] RATE_SPS_3 = 10'h3E8;
    localparam logic [2:0] CH_GROUND = 3'h4;

    // result and register read widths in bytes
    localparam int RESULT_BYTES = 3;
    localparam logic [1:0] RESULT_LEN = 2'h3;
    localparam logic [1:0] REG_LEN = 2'h1;

    // host operations
    typedef enum logic [1:0] {
        ACR_OP_RESULT = 2'h0,
        ACR_OP_FETCH = 2'h1,
        ACR_OP_STORE = 2'h2
    } acr_op_e;
endpackage

// ===== design/acr_link_if.sv
// acr_link_if: byte-level frame link between host controller and converter.
// assumes a bit-level serial engine is abstracted away; one clock for both ends.
`timescale 1ns/1ps
interface acr_link_if;
    logic frm_start;
    logic frm_rd;
    logic frm_stop;
    logic wr_vld;
    logic [7:0] wr_byte;
    logic rd_req;
    logic rd_vld;
    logic [7:0] rd_byte;
    logic ready_n_out;
    logic ready_n_oe;
    logic ready_n_line;

    // open-drain ready line with pull-up
    assign ready_n_line = ready_n_oe ? ready_n_out : 1'b1;

    modport device (
        input frm_start, frm_rd, frm_stop, wr_vld, wr_byte, rd_req,
        output rd_vld, rd_byte, ready_n_out, ready_n_oe
    );
    modport host (
        output frm_start, frm_rd, frm_stop, wr_vld, wr_byte, rd_req,
        input rd_vld, rd_byte, ready_n_line
    );
endinterface

// ===== design/acr_device.sv
// acr_device: command decoder, configuration and status registers of the converter.
// assumes the analog core pulses conv_done with conv_result, and the host obeys frame order.
`timescale 1ns/1ps
module acr_device #(
    parameter logic [6:0] IDENTITY = 7'h15 // arbitrary value
) (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // link to host
    acr_link_if.device link,
    // analog core side
    input wire logic conv_done,
    input wire logic [23:0] conv_result,
    input wire logic power_down,
    // configuration out
    output logic [2:0] input_select,
    output logic [2:0] ain_pos,
    output logic [2:0] ain_neg,
    output logic [2:0] gain_factor,
    output logic [1:0] sample_rate_sel,
    output logic [9:0] rate_sps,
    output logic conversion_mode_sel,
    output logic ext_ref_sel,
    output logic filter_restart,
    output logic status_ready
);
    logic [7:0] cfg_reg, cfg_next;
    logic ready_reg, ready_next;
    logic [23:0] latest_reg;
    logic [23:0] obuf_reg, obuf_next;
    logic [1:0] olen_reg, olen_next;
    logic first_reg, first_next;
    logic store_pend_reg, store_pend_next;
    logic rd_vld_reg;
    logic [7:0] rd_byte_reg;
    logic restart_reg;
    logic [2:0] pos_reg, neg_reg, gain_reg;
    logic [9:0] sps_reg;
    logic ready_oe_reg;
    logic [2:0] pos_next, neg_next;
    logic [9:0] sps_next;

    // command decode on a byte that completes inside a write frame
    wire cmd_byte = link.wr_vld && first_reg;
    wire is_rdata = (link.wr_byte & acr_pkg::CMD_RDATA_MSK) == acr_pkg::CMD_RDATA_VAL;
    wire is_fetch = (link.wr_byte & acr_pkg::CMD_FETCH_MSK) == acr_pkg::CMD_FETCH_VAL;
    wire is_store = (link.wr_byte & acr_pkg::CMD_STORE_MSK) == acr_pkg::CMD_STORE_VAL;
    wire do_rdata = cmd_byte && is_rdata;
    wire do_fetch = cmd_byte && is_fetch;
    wire do_store_cmd = cmd_byte && is_store;
    wire do_store = link.wr_vld && !first_reg && store_pend_reg;
    wire fetch_addr = link.wr_byte[acr_pkg::CMD_ADDR_BIT];
    wire [7:0] status_val = {ready_reg, IDENTITY};
    wire [7:0] fetch_val = (fetch_addr == acr_pkg::OFS_STATUS) ? status_val : cfg_reg;

    // field views of the configuration register
    wire [2:0] f_insel = cfg_reg[acr_pkg::CFG_INSEL_HI:acr_pkg::CFG_INSEL_LO];
    wire f_gain = cfg_reg[acr_pkg::CFG_GAIN_BIT];
    wire [1:0] f_rate = cfg_reg[acr_pkg::CFG_RATE_HI:acr_pkg::CFG_RATE_LO];
    wire f_mode = cfg_reg[acr_pkg::CFG_MODE_BIT];
    wire f_vref = cfg_reg[acr_pkg::CFG_VREF_BIT];

    // configuration only changes by a store data byte; power-down leaves it alone
    always_comb begin
        cfg_next = cfg_reg;
        if (do_store) begin
            cfg_next = link.wr_byte;
        end
    end

    // ready flag: a finishing conversion wins over the clear of a result read
    always_comb begin
        ready_next = ready_reg;
        if (do_rdata) begin
            ready_next = 1'b0;
        end
        if (conv_done) begin
            ready_next = 1'b1;
        end
    end

    // output buffer and command tracking; unknown bytes fall through untouched
    always_comb begin
        obuf_next = obuf_reg;
        olen_next = olen_reg;
        first_next = first_reg;
        store_pend_next = store_pend_reg;
        if (link.frm_start) begin
            first_next = !link.frm_rd;
            store_pend_next = 1'b0;
        end else if (link.frm_stop) begin
            first_next = 1'b0;
            store_pend_next = 1'b0;
        end else if (link.wr_vld) begin
            first_next = 1'b0;
            store_pend_next = do_store_cmd;
            if (do_rdata) begin
                // old result goes out if the new one lands this same cycle
                obuf_next = latest_reg;
                olen_next = acr_pkg::RESULT_LEN;
            end else if (do_fetch) begin
                obuf_next = {fetch_val, 16'h0000};
                olen_next = acr_pkg::REG_LEN;
            end
        end else if (link.rd_req) begin
            // read frame shifts msb first; past the end zeros come out
            obuf_next = {obuf_reg[15:0], 8'h00};
            if (olen_reg != 2'h0) begin
                olen_next = olen_reg - 2'h1;
            end
        end
    end

    // registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_reg <= acr_pkg::CONFIG_RESET;
            ready_reg <= 1'b0;
            latest_reg <= 24'h000000;
            obuf_reg <= 24'h000000;
            olen_reg <= 2'h0;
            first_reg <= 1'b0;
            store_pend_reg <= 1'b0;
        end else if (ce) begin
            cfg_reg <= cfg_next;
            ready_reg <= ready_next;
            obuf_reg <= obuf_next;
            olen_reg <= olen_next;
            first_reg <= first_next;
            store_pend_reg <= store_pend_next;
            if (conv_done) begin
                latest_reg <= conv_result;
            end
        end
    end

    // read byte answers one cycle after each request
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_vld_reg <= 1'b0;
            rd_byte_reg <= 8'h00;
        end else if (ce) begin
            rd_vld_reg <= link.rd_req;
            if (link.rd_req) begin
                rd_byte_reg <= obuf_reg[23:16];
            end
        end
    end

    // filter restart pulse on each accepted store data byte
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            restart_reg <= 1'b0;
        end else if (ce) begin
            restart_reg <= do_store;
        end
    end

    // ready pin pulls low while a result is unread
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ready_oe_reg <= 1'b0;
        end else if (ce) begin
            ready_oe_reg <= ready_next;
        end
    end

    // input pair decode; 111 is taken as a repeat of 110
    always_comb begin
        case (f_insel)
            3'h0: begin
                pos_next = 3'h0;
                neg_next = 3'h1;
            end
            3'h1: begin
                pos_next = 3'h2;
                neg_next = 3'h3;
            end
            3'h2: begin
                pos_next = 3'h1;
                neg_next = 3'h2;
            end
            3'h3: begin
                pos_next = 3'h0;
                neg_next = acr_pkg::CH_GROUND;
            end
            3'h4: begin
                pos_next = 3'h1;
                neg_next = acr_pkg::CH_GROUND;
            end
            3'h5: begin
                pos_next = 3'h2;
                neg_next = acr_pkg::CH_GROUND;
            end
            default: begin
                pos_next = 3'h3;
                neg_next = acr_pkg::CH_GROUND;
            end
        endcase
    end

    // rate decode sets the conversion rate in samples per second seen by the core
    always_comb begin
        case (f_rate)
            2'h0: sps_next = acr_pkg::RATE_SPS_0;
            2'h1: sps_next = acr_pkg::RATE_SPS_1;
            2'h2: sps_next = acr_pkg::RATE_SPS_2;
            default: sps_next = acr_pkg::RATE_SPS_3;
        endcase
    end

    // decoded settings are registered so each decoded output leaves a flip-flop
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pos_reg <= 3'h0;
            neg_reg <= 3'h1;
            gain_reg <= acr_pkg::GAIN_LOW;
            sps_reg <= acr_pkg::RATE_SPS_0;
        end else if (ce) begin
            pos_reg <= pos_next;
            neg_reg <= neg_next;
            gain_reg <= f_gain ? acr_pkg::GAIN_HIGH : acr_pkg::GAIN_LOW;
            sps_reg <= sps_next;
        end
    end

    // outputs
    assign link.rd_vld = rd_vld_reg;
    assign link.rd_byte = rd_byte_reg;
    assign link.ready_n_out = 1'b0;
    assign link.ready_n_oe = ready_oe_reg;
    assign input_select = f_insel;
    assign ain_pos = pos_reg;
    assign ain_neg = neg_reg;
    assign gain_factor = gain_reg;
    assign sample_rate_sel = f_rate;
    assign rate_sps = sps_reg;
    assign conversion_mode_sel = f_mode;
    assign ext_ref_sel = f_vref;
    assign filter_restart = restart_reg;
    assign status_ready = ready_reg;
    // power_down deliberately touches no register state
    wire unused_pd = power_down;
endmodule // acr_device

// ===== design/acr_host.sv
// acr_host: host controller end issuing result reads, register fetches and stores.
// assumes the link partner answers each read request; ready line arrives as a pin.
`timescale 1ns/1ps
module acr_host (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // link to device
    acr_link_if.host link,
    // user requests
    input wire logic cmd_valid,
    input wire acr_pkg::acr_op_e cmd_op,
    input wire logic cmd_addr,
    input wire logic [7:0] cmd_data,
    // user answers
    output logic cmd_busy,
    output logic resp_valid,
    output logic [23:0] resp_data,
    output logic result_ready_fall
);
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_WSTART = 3'h1,
        S_WBYTE = 3'h3,
        S_WSTOP = 3'h2,
        S_RSTART = 3'h6,
        S_RBYTE = 3'h7,
        S_RSTOP = 3'h5,
        S_DONE = 3'h4
    } acr_hst_e;

    acr_hst_e st_reg, st_next;
    acr_pkg::acr_op_e op_reg;
    logic [7:0] cmd_reg, data_reg;
    logic [1:0] cnt_reg;
    logic pend_reg;
    logic [23:0] shift_reg;
    logic f_start_reg, f_rd_reg, f_stop_reg, wr_vld_reg, rd_req_reg;
    logic [7:0] wr_byte_reg;
    logic rdy_s1_reg, rdy_s2_reg, rdy_s3_reg, fall_reg, resp_reg;
    logic busy_reg;

    // command byte built from the request
    wire [7:0] cmd_byte = (cmd_op == acr_pkg::ACR_OP_RESULT) ? acr_pkg::CMD_RDATA_VAL :
                          (cmd_op == acr_pkg::ACR_OP_FETCH) ?
                          (acr_pkg::CMD_FETCH_VAL | {5'h00, cmd_addr, 2'h0}) : acr_pkg::CMD_STORE_VAL;
    wire [1:0] wr_len = (op_reg == acr_pkg::ACR_OP_STORE) ? 2'h2 : 2'h1;
    wire [1:0] rd_len = (op_reg == acr_pkg::ACR_OP_RESULT) ? acr_pkg::RESULT_LEN : acr_pkg::REG_LEN;
    wire last_wr = cnt_reg == wr_len - 2'h1;
    wire last_rd = cnt_reg == rd_len - 2'h1;

    // sequence: write frame with command, then read frame unless storing
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            S_IDLE: if (cmd_valid) st_next = S_WSTART;
            S_WSTART: st_next = S_WBYTE;
            S_WBYTE: if (last_wr) st_next = S_WSTOP;
            S_WSTOP: st_next = (op_reg == acr_pkg::ACR_OP_STORE) ? S_DONE : S_RSTART;
            S_RSTART: st_next = S_RBYTE;
            S_RBYTE: if (link.rd_vld && last_rd) st_next = S_RSTOP;
            S_RSTOP: st_next = S_DONE;
            default: st_next = S_IDLE;
        endcase
    end

    // state, counters and captured data
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg <= S_IDLE;
            busy_reg <= 1'b0;
            op_reg <= acr_pkg::ACR_OP_RESULT;
            cmd_reg <= 8'h00;
            data_reg <= 8'h00;
            cnt_reg <= 2'h0;
            pend_reg <= 1'b0;
            shift_reg <= 24'h000000;
        end else if (ce) begin
            st_reg <= st_next;
            busy_reg <= st_next != S_IDLE;
            if (st_reg == S_IDLE && cmd_valid) begin
                op_reg <= cmd_op;
                cmd_reg <= cmd_byte;
                data_reg <= cmd_data;
                shift_reg <= 24'h000000;
            end
            if (st_reg == S_WSTART || st_reg == S_RSTART) begin
                cnt_reg <= 2'h0;
            end else if (st_reg == S_WBYTE) begin
                cnt_reg <= cnt_reg + 2'h1;
            end else if (st_reg == S_RBYTE && link.rd_vld) begin
                cnt_reg <= cnt_reg + 2'h1;
                shift_reg <= {shift_reg[15:0], link.rd_byte};
            end
            pend_reg <= (st_reg == S_RBYTE) && !link.rd_vld && (pend_reg || rd_req_reg);
        end
    end

    // link strobes, one cycle per event; frm_rd stays high through the read frame
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            f_start_reg <= 1'b0;
            f_rd_reg <= 1'b0;
            f_stop_reg <= 1'b0;
            wr_vld_reg <= 1'b0;
            wr_byte_reg <= 8'h00;
            rd_req_reg <= 1'b0;
        end else if (ce) begin
            f_start_reg <= st_next == S_WSTART || st_next == S_RSTART;
            f_rd_reg <= st_next == S_RSTART || st_next == S_RBYTE;
            f_stop_reg <= st_next == S_WSTOP || st_next == S_RSTOP;
            wr_vld_reg <= st_reg == S_WSTART || (st_reg == S_WBYTE && !last_wr);
            wr_byte_reg <= (st_reg == S_WSTART) ? cmd_reg : data_reg;
            rd_req_reg <= st_next == S_RBYTE && !pend_reg && !rd_req_reg && !link.rd_vld;
        end
    end

    // ready pin is asynchronous to this logic: two flops, then edge detect
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdy_s1_reg <= 1'b1;
            rdy_s2_reg <= 1'b1;
            rdy_s3_reg <= 1'b1;
            fall_reg <= 1'b0;
            resp_reg <= 1'b0;
        end else if (ce) begin
            rdy_s1_reg <= link.ready_n_line;
            rdy_s2_reg <= rdy_s1_reg;
            rdy_s3_reg <= rdy_s2_reg;
            fall_reg <= rdy_s3_reg && !rdy_s2_reg;
            resp_reg <= st_reg == S_DONE;
        end
    end

    // outputs
    assign link.frm_start = f_start_reg;
    assign link.frm_rd = f_rd_reg;
    assign link.frm_stop = f_stop_reg;
    assign link.wr_vld = wr_vld_reg;
    assign link.wr_byte = wr_byte_reg;
    assign link.rd_req = rd_req_reg;
    assign cmd_busy = busy_reg;
    assign resp_valid = resp_reg;
    assign resp_data = shift_reg;
    assign result_ready_fall = fall_reg;
endmodule // acr_host

// ===== verif/acr_link_properties.sv
// acr_link_properties: timing relations on the byte link between host and converter.
// assumes one clock domain; instantiated beside the link interface in tb_top.
`timescale 1ns/1ps
module acr_link_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // link signals
    input wire logic frm_start,
    input wire logic frm_rd,
    input wire logic wr_vld,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    input wire logic rd_vld,
    input wire logic [7:0] rd_byte,
    input wire logic ready_n_out,
    input wire logic ready_n_oe,
    // analog core strobe
    input wire logic conv_done
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // only the first byte of a write frame is a command; later bytes are data
    logic cmd_slot_reg;
    logic cmd_slot_next;
    logic res_cmd;
    logic store_cmd;
    assign cmd_slot_next = frm_start ? !frm_rd : (wr_vld ? 1'h0 : cmd_slot_reg);
    assign res_cmd = wr_vld && cmd_slot_reg && ((wr_byte & acr_pkg::CMD_RDATA_MSK) == acr_pkg::CMD_RDATA_VAL);
    assign store_cmd = wr_vld && cmd_slot_reg && ((wr_byte & acr_pkg::CMD_STORE_MSK) == acr_pkg::CMD_STORE_VAL);

    // command slot tracker
    always_ff @(posedge ref_clk) begin
        cmd_slot_reg <= srst ? 1'h0 : cmd_slot_next;
    end

    chk_read_answer_lat: assert property (rd_req |=> rd_vld)
        else $error("read request not answered next cycle");
    chk_no_stray_answer: assert property (rd_vld |-> $past(rd_req))
        else $error("read answer without request");
    chk_read_byte_hold: assert property ($changed(rd_byte) |-> rd_vld)
        else $error("read byte changed outside an answer");
    chk_ready_pin_set: assert property (conv_done |=> ready_n_oe)
        else $error("ready pin not pulled low after new result");
    chk_ready_set_cause: assert property ($rose(ready_n_oe) |-> $past(conv_done))
        else $error("ready pin pulled low without a new result");
    chk_ready_read_clear: assert property (res_cmd && !conv_done |=> !ready_n_oe)
        else $error("ready pin not released after result command");
    chk_ready_race_kept: assert property (res_cmd && conv_done |=> ready_n_oe)
        else $error("ready pin released although a newer result arrived");
    chk_ready_clear_cause: assert property ($fell(ready_n_oe) |-> $past(res_cmd))
        else $error("ready pin released without result command");
    chk_pin_drain_only: assert property (ready_n_oe |-> ready_n_out == 1'h0)
        else $error("ready pin driven high");

    // main scenarios reached
    cov_result_cmd: cover property (res_cmd);
    cov_result_race: cover property (res_cmd && conv_done);
    cov_store_cmd: cover property (store_cmd);
    cov_read_byte: cover property (rd_vld && frm_rd);
endmodule // acr_link_properties

// ===== verif/tb_top.sv
// tb_top: drives the host user side and the analog side, both ends joined by the link.
// assumes the package, interface and both design ends are compiled first.
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] TB_IDENT = 7'h2A; // arbitrary value
    logic ref_clk;
    logic srst;
    logic conv_done;
    logic [23:0] conv_result;
    logic power_down;
    logic [2:0] input_select, ain_pos, ain_neg, gain_factor;
    logic [1:0] sample_rate_sel;
    logic [9:0] rate_sps;
    logic conversion_mode_sel, ext_ref_sel, filter_restart, status_ready;
    logic cmd_valid, cmd_addr, cmd_busy, resp_valid, result_ready_fall;
    acr_pkg::acr_op_e cmd_op;
    logic [7:0] cmd_data, d;
    logic [23:0] resp_data, got;
    int err_count = 0;
    int checked = 0;
    int fall_cnt = 0;
    int restart_cnt = 0;
    logic [2:0] pos_tab [8] = '{3'h0, 3'h2, 3'h1, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3};
    logic [2:0] neg_tab [8] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
    logic [9:0] rate_tab [4] = '{10'h014, 10'h05A, 10'h14A, 10'h3E8};

    // the two ends face each other across one link
    acr_link_if u_acr_link_if();
    acr_device #(.IDENTITY(TB_IDENT)) u_acr_device (.ref_clk(ref_clk), .srst(srst), .ce(1'h1),
        .link(u_acr_link_if), .conv_done(conv_done), .conv_result(conv_result), .power_down(power_down),
        .input_select(input_select), .ain_pos(ain_pos), .ain_neg(ain_neg), .gain_factor(gain_factor),
        .sample_rate_sel(sample_rate_sel), .rate_sps(rate_sps), .conversion_mode_sel(conversion_mode_sel),
        .ext_ref_sel(ext_ref_sel), .filter_restart(filter_restart), .status_ready(status_ready));
    acr_host u_acr_host (.ref_clk(ref_clk), .srst(srst), .ce(1'h1), .link(u_acr_link_if),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_busy(cmd_busy), .resp_valid(resp_valid), .resp_data(resp_data),
        .result_ready_fall(result_ready_fall));
    acr_link_properties u_acr_link_properties (.ref_clk(ref_clk), .srst(srst),
        .frm_start(u_acr_link_if.frm_start), .frm_rd(u_acr_link_if.frm_rd), .wr_vld(u_acr_link_if.wr_vld),
        .wr_byte(u_acr_link_if.wr_byte), .rd_req(u_acr_link_if.rd_req), .rd_vld(u_acr_link_if.rd_vld),
        .rd_byte(u_acr_link_if.rd_byte), .ready_n_out(u_acr_link_if.ready_n_out),
        .ready_n_oe(u_acr_link_if.ready_n_oe), .conv_done(conv_done));

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    // pulse counters, compared against the count the sequence should produce
    always @(posedge ref_clk) begin
        if (result_ready_fall === 1'h1) fall_cnt++;
        if (filter_restart === 1'h1) restart_cnt++;
    end

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task give_verdict();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // one host operation; cmd_valid drops as soon as the host leaves idle
    task automatic run_op(input acr_pkg::acr_op_e op, input logic a, input logic [7:0] v, output logic [23:0] r);
        int n;
        r = 'x;
        @(posedge ref_clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= v;
        cmd_valid <= 1'h1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cmd_busy !== 1'h1 && n < 50);
        cmd_valid <= 1'h0;
        n = 0;
        // at least four cycles are waited; the edge that first sees busy low still samples the response
        while (n < 200 && (cmd_busy === 1'h1 || n < 4)) begin
            @(posedge ref_clk);
            if (resp_valid === 1'h1) r = resp_data;
            n++;
        end
        // a host that never returns to idle counts as a mismatch
        if (cmd_busy !== 1'h0) err_count++;
    endtask

    task automatic new_result(input logic [23:0] v);
        @(posedge ref_clk);
        conv_done <= 1'h1;
        conv_result <= v;
        @(posedge ref_clk);
        conv_done <= 1'h0;
        repeat (6) @(posedge ref_clk);
    endtask

    // result read with a new result landing on the command byte or on the first read answer
    task automatic race_read(input logic on_rd, input logic [23:0] v, output logic [23:0] r);
        int n;
        fork
            run_op(acr_pkg::ACR_OP_RESULT, 1'h0, 8'h00, r);
            begin
                n = 0;
                do begin
                    @(posedge ref_clk);
                    n++;
                end while (n < 60 && !(on_rd ? u_acr_link_if.rd_req === 1'h1 :
                    (u_acr_link_if.frm_start === 1'h1 && u_acr_link_if.frm_rd === 1'h0)));
                conv_done <= 1'h1;
                conv_result <= v;
                @(posedge ref_clk);
                conv_done <= 1'h0;
            end
        join
    endtask

    // watchdog: the sequence needs a few thousand cycles at most
    initial begin
        #80000;
        err_count++;
        give_verdict();
    end

    // main sequence
    initial begin
        ref_clk = 1'h0;
        srst = 1'h1;
        conv_done = 1'h0;
        conv_result = 24'h000000;
        power_down = 1'h0;
        cmd_valid = 1'h0;
        cmd_op = acr_pkg::ACR_OP_RESULT;
        cmd_addr = 1'h0;
        cmd_data = 8'h00;
        repeat (20) @(posedge ref_clk);
        srst <= 1'h0;
        @(posedge ref_clk);
        check("chan_rst", {input_select, ain_pos, ain_neg}, {3'h0, 3'h0, 3'h1});
        check("fmt_rst", {gain_factor, sample_rate_sel, rate_sps, conversion_mode_sel, ext_ref_sel},
            {3'h1, 2'h0, 10'h014, 1'h0, 1'h0});
        run_op(acr_pkg::ACR_OP_FETCH, 1'h0, 8'h00, got);
        check("reg0_rst", got, 24'h000000);
        run_op(acr_pkg::ACR_OP_FETCH, 1'h1, 8'h00, got);
        check("reg1_rst", got, {17'h00000, TB_IDENT});
        // every input select code, the other fields walked along with it
        for (int i = 0; i < 8; i++) begin
            d = {i[2:0], i[0], i[1:0], i[1], i[2]};
            run_op(acr_pkg::ACR_OP_STORE, 1'h0, d, got);
            check("chan", {input_select, ain_pos, ain_neg}, {d[7:5], pos_tab[i], neg_tab[i]});
            check("fmt", {gain_factor, sample_rate_sel, rate_sps, conversion_mode_sel, ext_ref_sel},
                {(d[4] ? 3'h4 : 3'h1), d[3:2], rate_tab[d[3:2]], d[1], d[0]});
            run_op(acr_pkg::ACR_OP_FETCH, 1'h0, 8'h00, got);
            check("reg0", got, {16'h0000, d});
        end
        check("restarts", 24'(restart_cnt), 24'h000008);
        power_down <= 1'h1;
        repeat (10) @(posedge ref_clk);
        run_op(acr_pkg::ACR_OP_FETCH, 1'h0, 8'h00, got);
        check("reg0_pd", got, 24'h0000FF);
        power_down <= 1'h0;
        new_result(24'hA5C3E1);
        check("line_new", 24'(u_acr_link_if.ready_n_line), 24'h000000);
        check("flag_new", 24'(status_ready), 24'h000001);
        run_op(acr_pkg::ACR_OP_FETCH, 1'h1, 8'h00, got);
        check("reg1_new", got, {16'h0000, 1'h1, TB_IDENT});
        run_op(acr_pkg::ACR_OP_RESULT, 1'h0, 8'h00, got);
        check("result_a", got, 24'hA5C3E1);
        check("line_read", 24'(u_acr_link_if.ready_n_line), 24'h000001);
        check("flag_read", 24'(status_ready), 24'h000000);
        race_read(1'h1, 24'h5A3C1E, got);
        check("result_mid", got, 24'hA5C3E1);
        check("line_mid", 24'(u_acr_link_if.ready_n_line), 24'h000000);
        run_op(acr_pkg::ACR_OP_RESULT, 1'h0, 8'h00, got);
        check("result_b", got, 24'h5A3C1E);
        race_read(1'h0, 24'h00FF81, got);
        check("result_race", got, 24'h5A3C1E);
        check("line_race", 24'(u_acr_link_if.ready_n_line), 24'h000000);
        run_op(acr_pkg::ACR_OP_RESULT, 1'h0, 8'h00, got);
        check("result_c", got, 24'h00FF81);
        check("line_c", 24'(u_acr_link_if.ready_n_line), 24'h000001);
        repeat (8) @(posedge ref_clk);
        check("falls", 24'(fall_cnt), 24'h000003);
        check("restarts_end", 24'(restart_cnt), 24'h000008);
        give_verdict();
    end
endmodule // tb_top
